// [ati_cfg.svh]
`ifndef ATI_CFG_SVH
`define ATI_CFG_SVH

// Geometry of the switch and of each filter table.
`define ATI_NPORT          3
`define ATI_NENTRY         16
`define ATI_NBYTE          16
`define ATI_ADDR_W         18

// Register index layout: 0xN6xx, byte address is four times the index.
`define ATI_WIN_NIBBLE     4'h6
`define ATI_IDX_LAST_DATA  8'h0F
`define ATI_IDX_BE_UPPER   8'h10
`define ATI_IDX_BE_LOWER   8'h11
`define ATI_IDX_CTRL       8'h12

// Entry byte that carries no content.
`define ATI_UNUSED_BYTE    4'hC

// Access control register fields.
`define ATI_CTRL_DIR_BIT   4
`define ATI_CTRL_RDST_BIT  5
`define ATI_CTRL_WRST_BIT  6
`define ATI_CTRL_BUSY_BIT  7

// Matching, action and process byte offsets within an entry.
`define ATI_OFS_MODE       4'h1
`define ATI_OFS_ACT_HI     4'hA
`define ATI_OFS_ACT_LO     4'hB
`define ATI_OFS_MASK_HI    4'hE
`define ATI_OFS_MASK_LO    4'hF

// Reset values.
`define ATI_RST_BYTE       8'h00
`define ATI_RST_BE_UPPER   8'h00
`define ATI_RST_BE_LOWER   8'h00

`endif

// [ati_pkg.sv]
package ati_pkg;

	// Phase of one indirect table operation.
	typedef enum logic [1:0] {
		ATI_IDLE,
		ATI_READ,
		ATI_WRITE
	} ati_op_t;

	typedef logic [7:0] ati_byte_t;
	typedef logic [3:0] ati_idx_t;

endpackage : ati_pkg

// [ati_table_access.sv]
`timescale 1ns/1ns
`include "ati_cfg.svh"

module ati_table_access (
	input  wire logic                           core_clk,
	input  wire logic                           arst_n,
	// Register bus, slave side.
	input  wire logic                           psel,
	input  wire logic                           penable,
	input  wire logic                           pwrite,
	input  wire logic [`ATI_ADDR_W-1:0]         paddr,
	input  wire logic [31:0]                    pwdata,
	output logic      [31:0]                    prdata,
	output logic                                pready,
	output logic                                pslverr,
	// Lookup side: one entry number in, one field view out, per port.
	input  wire ati_pkg::ati_idx_t [`ATI_NPORT-1:0] lookup_entry,
	output logic [`ATI_NPORT-1:0][1:0]          match_mode,
	output logic [`ATI_NPORT-1:0][1:0]          match_enable_select,
	output logic [`ATI_NPORT-1:0][1:0]          priority_mode,
	output logic [`ATI_NPORT-1:0][2:0]          priority_value,
	output logic [`ATI_NPORT-1:0]               remap_priority_enable,
	output logic [`ATI_NPORT-1:0][2:0]          remapped_priority,
	output logic [`ATI_NPORT-1:0][1:0]          map_mode,
	output logic [`ATI_NPORT-1:0][15:0]         process_rule_mask
);
	import ati_pkg::*;

	// Port number carried in the upper index nibble, or zero if unmapped.
	// Zero doubles as the error code, since this window has no port 0;
	// anything past the control index is unmapped as well.
	function automatic logic [2:0] port_of(input logic [15:0] idx);
		logic [2:0] r;
		r = 3'h0;
		if (idx[11:8] == `ATI_WIN_NIBBLE && idx[15:12] != 4'h0 &&
		    idx[15:12] <= 4'(`ATI_NPORT) && idx[7:0] <= `ATI_IDX_CTRL) begin
			r = idx[14:12];
		end
		return r;
	endfunction : port_of

	// Enable bit governing an entry byte; the order runs backwards.
	// Byte C holds nothing, so its enable is masked whatever its value.
	function automatic logic byte_enabled(input logic [15:0] be,
	                                      input logic [3:0]  b);
		logic r;
		r = be[4'hF - b];
		if (b == `ATI_UNUSED_BYTE) begin
			r = 1'b0;
		end
		return r;
	endfunction : byte_enabled

	logic [15:0] reg_idx;
	logic [2:0]  sel_port;
	logic        setup_ph;
	logic        access_ph;
	logic [31:0] prdata_q;
	logic        pslverr_q;
	logic [`ATI_NPORT-1:0][31:0] port_rd;

	// Register index is the word address; the two low address bits are
	// ignored, as every register sits alone in the low byte of a word.
	assign reg_idx   = paddr[17:2];
	assign sel_port  = port_of(reg_idx);
	assign setup_ph  = psel && !penable;
	assign access_ph = psel && penable;

	// Zero-wait slave: every access completes in its first access cycle.
	assign pready  = access_ph;
	assign prdata  = prdata_q;
	assign pslverr = pslverr_q;

	// Error flag is decided in the setup cycle from the address alone, so
	// the access cycle can answer with no wait state.
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			pslverr_q <= 1'b0;
		end else if (setup_ph) begin
			pslverr_q <= (sel_port == 3'h0);
		end
	end

	// Read data is captured in the setup cycle as well and presented
	// straight from flip-flops; unmapped and write transfers read zero.
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			prdata_q <= 32'h0000_0000;
		end else if (setup_ph) begin
			if (sel_port != 3'h0 && !pwrite) begin
				prdata_q <= port_rd[sel_port - 3'h1];
			end else begin
				prdata_q <= 32'h0000_0000;
			end
		end
	end

	// Each port gets a full copy of the staging and table logic. That
	// costs area three times over, but it keeps the ports truly separate:
	// a command on one port can never stall or disturb another.
	genvar p;
	generate
		for (p = 0; p < `ATI_NPORT; p++) begin : g_port
			// Every port owns its own table and staging registers.
			ati_byte_t   tbl_q  [`ATI_NENTRY][`ATI_NBYTE];
			ati_byte_t   data_q [`ATI_NBYTE];
			logic [15:0] be_q;
			ati_idx_t    entry_select_q;
			logic        dir_q;
			logic        rd_done_q;
			logic        wr_done_q;
			ati_op_t     op_q;
			logic        hit;
			logic        wr_hit;
			logic [7:0]  ofs;
			logic        start;
			ati_byte_t   ctrl_rd;
			ati_byte_t   reg_rd;
			logic        busy;
			logic        data_wr;

			// Port decode, register offset and write strobe for this port.
			assign hit    = (sel_port == 3'(p + 1));
			assign ofs    = reg_idx[7:0];
			assign wr_hit = access_ph && pwrite && hit;
			// A new command is refused while one is still in flight. The
			// refusal is silent, so software must poll the done bits first.
			assign busy    = (op_q != ATI_IDLE);
			assign start   = wr_hit && ofs == `ATI_IDX_CTRL && !busy;
			// Staging writes skip byte C, which holds nothing.
			assign data_wr = wr_hit && ofs <= `ATI_IDX_LAST_DATA &&
			                 ofs[3:0] != `ATI_UNUSED_BYTE;

			// Control read-back: busy, done flags, direction and index.
			assign ctrl_rd = {busy, wr_done_q, rd_done_q,
			                  dir_q, entry_select_q};

			// Read mux for this port; byte C and gaps read as zero.
			// It is sampled into prdata_q only in the setup cycle, so its
			// depth stays off the access path.
			always_comb begin
				reg_rd = 8'h00;
				if (ofs <= `ATI_IDX_LAST_DATA) begin
					if (ofs[3:0] != `ATI_UNUSED_BYTE) begin
						reg_rd = data_q[ofs[3:0]];
					end
				end else if (ofs == `ATI_IDX_BE_UPPER) begin
					reg_rd = be_q[15:8];
				end else if (ofs == `ATI_IDX_BE_LOWER) begin
					reg_rd = be_q[7:0];
				end else if (ofs == `ATI_IDX_CTRL) begin
					reg_rd = ctrl_rd;
				end
			end
			assign port_rd[p] = {24'h00_0000, reg_rd};

			// Upper enable register: governs data bytes 0 to 7.
			always_ff @(posedge core_clk or negedge arst_n) begin
				if (!arst_n) begin
					be_q[15:8] <= `ATI_RST_BE_UPPER;
				end else if (wr_hit && ofs == `ATI_IDX_BE_UPPER) begin
					be_q[15:8] <= pwdata[7:0];
				end
			end

			// Lower enable register: governs data bytes 8 to F.
			always_ff @(posedge core_clk or negedge arst_n) begin
				if (!arst_n) begin
					be_q[7:0] <= `ATI_RST_BE_LOWER;
				end else if (wr_hit && ofs == `ATI_IDX_BE_LOWER) begin
					be_q[7:0] <= pwdata[7:0];
				end
			end

			// Index and direction are latched by the write that starts a
			// command and then stay put until the next accepted start.
			always_ff @(posedge core_clk or negedge arst_n) begin
				if (!arst_n) begin
					entry_select_q <= 4'h0;
					dir_q          <= 1'b0;
				end else if (start) begin
					entry_select_q <= pwdata[3:0];
					dir_q          <= pwdata[`ATI_CTRL_DIR_BIT];
				end
			end

			// Done flags: a start clears both, the finishing cycle sets one.
			// Setting is given priority, although a start cannot fall in a
			// finishing cycle while the sequencer refuses starts when busy.
			always_ff @(posedge core_clk or negedge arst_n) begin
				if (!arst_n) begin
					rd_done_q <= 1'b0;
					wr_done_q <= 1'b0;
				end else if (op_q == ATI_READ) begin
					rd_done_q <= 1'b1;
				end else if (op_q == ATI_WRITE) begin
					wr_done_q <= 1'b1;
				end else if (start) begin
					rd_done_q <= 1'b0;
					wr_done_q <= 1'b0;
				end
			end

			// One-cycle sequencer; the direction bit picks the operation.
			always_ff @(posedge core_clk or negedge arst_n) begin
				if (!arst_n) begin
					op_q <= ATI_IDLE;
				end else begin
					case (op_q)
						ATI_IDLE: begin
							if (start && pwdata[`ATI_CTRL_DIR_BIT]) begin
								op_q <= ATI_WRITE;
							end else if (start) begin
								op_q <= ATI_READ;
							end
						end
						ATI_READ: begin
							op_q <= ATI_IDLE;
						end
						ATI_WRITE: begin
							op_q <= ATI_IDLE;
						end
						default: begin
							op_q <= ATI_IDLE;
						end
					endcase
				end
			end

			// Staging bytes: software writes, or a table read reloads all.
			// A staging write in the load cycle is lost; the load wins.
			always_ff @(posedge core_clk or negedge arst_n) begin
				if (!arst_n) begin
					for (int b = 0; b < `ATI_NBYTE; b++) begin
						data_q[b] <= `ATI_RST_BYTE;
					end
				end else if (op_q == ATI_READ) begin
					for (int b = 0; b < `ATI_NBYTE; b++) begin
						data_q[b] <= tbl_q[entry_select_q][b];
					end
				end else if (data_wr) begin
					data_q[ofs[3:0]] <= pwdata[7:0];
				end
			end

			// Table store; only enabled bytes change, byte C never does.
			// It lands one cycle after the start, from the staged bytes.
			always_ff @(posedge core_clk or negedge arst_n) begin
				if (!arst_n) begin
					for (int e = 0; e < `ATI_NENTRY; e++) begin
						for (int b = 0; b < `ATI_NBYTE; b++) begin
							tbl_q[e][b] <= `ATI_RST_BYTE;
						end
					end
				end else if (op_q == ATI_WRITE) begin
					for (int b = 0; b < `ATI_NBYTE; b++) begin
						if (byte_enabled(be_q, 4'(b))) begin
							tbl_q[entry_select_q][b] <= data_q[b];
						end
					end
				end
			end

			// Bytes of the entry that this port's filter consults. The
			// lookup index is live on every edge, so a table write shows in
			// the field view one cycle after it lands.
			ati_byte_t   view_mode;
			ati_byte_t   view_act_hi;
			ati_byte_t   view_act_lo;
			ati_byte_t   view_mask_hi;
			ati_byte_t   view_mask_lo;
			logic [1:0]  match_mode_q;
			logic [1:0]  match_enable_select_q;
			logic [1:0]  priority_mode_q;
			logic [2:0]  priority_value_q;
			logic        remap_priority_enable_q;
			logic [2:0]  remapped_priority_q;
			logic [1:0]  map_mode_q;
			logic [15:0] process_rule_mask_q;

			assign view_mode    = tbl_q[lookup_entry[p]][`ATI_OFS_MODE];
			assign view_act_hi  = tbl_q[lookup_entry[p]][`ATI_OFS_ACT_HI];
			assign view_act_lo  = tbl_q[lookup_entry[p]][`ATI_OFS_ACT_LO];
			assign view_mask_hi = tbl_q[lookup_entry[p]][`ATI_OFS_MASK_HI];
			assign view_mask_lo = tbl_q[lookup_entry[p]][`ATI_OFS_MASK_LO];

			// Matching part: mode and enable select of byte 01. The other
			// matching bytes are left to the filter engine to interpret.
			always_ff @(posedge core_clk or negedge arst_n) begin
				if (!arst_n) begin
					match_mode_q          <= 2'h0;
					match_enable_select_q <= 2'h0;
				end else begin
					match_mode_q          <= view_mode[5:4];
					match_enable_select_q <= view_mode[3:2];
				end
			end

			// Action part: priority fields of byte 0A; the remapped
			// priority straddles 0A and 0B, so it is rebuilt here whole.
			always_ff @(posedge core_clk or negedge arst_n) begin
				if (!arst_n) begin
					priority_mode_q         <= 2'h0;
					priority_value_q        <= 3'h0;
					remap_priority_enable_q <= 1'b0;
					remapped_priority_q     <= 3'h0;
				end else begin
					priority_mode_q         <= view_act_hi[7:6];
					priority_value_q        <= view_act_hi[5:3];
					remap_priority_enable_q <= view_act_hi[2];
					remapped_priority_q     <= {view_act_hi[1:0],
					                            view_act_lo[7]};
				end
			end

			// Action part: map mode in byte 0B.
			always_ff @(posedge core_clk or negedge arst_n) begin
				if (!arst_n) begin
					map_mode_q <= 2'h0;
				end else begin
					map_mode_q <= view_act_lo[6:5];
				end
			end

			// Process part: the rule-set mask, upper byte first.
			always_ff @(posedge core_clk or negedge arst_n) begin
				if (!arst_n) begin
					process_rule_mask_q <= 16'h0000;
				end else begin
					process_rule_mask_q <= {view_mask_hi,
					                        view_mask_lo};
				end
			end

			// Outputs come straight from the flip-flops above.
			assign match_mode[p]            = match_mode_q;
			assign match_enable_select[p]   = match_enable_select_q;
			assign priority_mode[p]         = priority_mode_q;
			assign priority_value[p]        = priority_value_q;
			assign remap_priority_enable[p] = remap_priority_enable_q;
			assign remapped_priority[p]     = remapped_priority_q;
			assign map_mode[p]              = map_mode_q;
			assign process_rule_mask[p]     = process_rule_mask_q;
		end
	endgenerate

endmodule : ati_table_access

// [ati_table_access_assertions.sv]
`timescale 1ns/1ns
`include "ati_cfg.svh"

module ati_table_access_assertions (
	input wire logic                               core_clk,
	input wire logic                               arst_n,
	input wire logic                               psel,
	input wire logic                               penable,
	input wire logic                               pwrite,
	input wire logic [`ATI_ADDR_W-1:0]             paddr,
	input wire logic [31:0]                        pwdata,
	input wire logic [31:0]                        prdata,
	input wire logic                               pready,
	input wire logic                               pslverr,
	input wire ati_pkg::ati_idx_t [`ATI_NPORT-1:0] lookup_entry,
	input wire logic [`ATI_NPORT-1:0][1:0]         map_mode,
	input wire logic [`ATI_NPORT-1:0][15:0]        process_rule_mask
);
	import ati_pkg::*;
	logic acc;
	logic bad;
	logic ctl;

	// Decode of the access phase and of the mapped window.
	assign acc = psel && penable;
	assign bad = !(paddr[17:14] != 4'h0 && paddr[17:14] <= `ATI_NPORT
		&& paddr[13:10] == `ATI_WIN_NIBBLE && paddr[9:2] <= `ATI_IDX_CTRL);
	assign ctl = !bad && paddr[9:2] == `ATI_IDX_CTRL;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!arst_n);

	AST_RDY: assert property (acc |-> pready)
		else $error("ready missing in access phase");
	AST_NRDY: assert property (!penable |-> !pready)
		else $error("ready outside access phase");
	AST_ERR: assert property (acc |-> pslverr == bad)
		else $error("error flag does not match decode");
	AST_HIZ: assert property (acc |-> prdata[31:8] == 24'h0)
		else $error("upper read data not zero");
	AST_BYTEC: assert property (acc && !bad && paddr[9:2] == 8'h0C
		|-> prdata == 32'h0)
		else $error("unused byte reads nonzero");
	// A start has finished by the time a transfer set up two cycles later looks at it.
	AST_DONE: assert property ((acc && pwrite && ctl) ##2 (psel && !penable
		&& !pwrite && paddr == $past(paddr, 2)) ##1 acc |-> prdata[7:0] ==
		{1'h0, $past(pwdata[4], 3), !$past(pwdata[4], 3),
		$past(pwdata[4:0], 3)})
		else $error("control status wrong after start");
	AST_HOLD: assert property ((!psel && $stable(lookup_entry))[*2] |=>
		$stable(process_rule_mask) && $stable(map_mode))
		else $error("lookup fields moved without cause");
endmodule : ati_table_access_assertions

bind ati_table_access ati_table_access_assertions u_chk (.*);

// [ati_table_access_bench.sv]
`timescale 1ns/1ns
`include "ati_cfg.svh"

module ati_table_access_bench;
	import ati_pkg::*;
	logic                   core_clk, arst_n, psel, penable, pwrite;
	logic                   pready, pslverr, er;
	logic [17:0]            paddr;
	logic [31:0]            pwdata, prdata, rd;
	ati_idx_t [2:0]         lookup_entry;
	logic [2:0][1:0]        match_mode, match_enable_select;
	logic [2:0][1:0]        priority_mode, map_mode;
	logic [2:0][2:0]        priority_value, remapped_priority;
	logic [2:0]             remap_priority_enable;
	logic [2:0][15:0]       process_rule_mask;
	int                     mismatches, compares, p, e, f, v, b;
	int                     mem[4][16][16], dr[4][16];

	ati_table_access DUT (.*);

	// Free running core clock.
	initial begin
		core_clk = 1'h0;
		forever #25 core_clk = ~core_clk;
	end

	task chk(input logic [31:0] s, input logic [31:0] x);
		compares++;
		if (s !== x) begin
			mismatches++;
			$display("BAD t=%0t seen=%h exp=%h", $time, s, x);
		end
	endtask : chk

	task final_report;
		if (mismatches == 0 && compares > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : final_report

	// One APB transfer to index {p,6,o}; the wait ends only on pready.
	task apb(input logic w, input logic [7:0] o, input logic [7:0] d);
		@(posedge core_clk);
		psel <= 1'h1;
		penable <= 1'h0;
		pwrite <= w;
		paddr <= {p[3:0], `ATI_WIN_NIBBLE, o, 2'h0};
		pwdata <= {24'h0, d};
		@(posedge core_clk);
		penable <= 1'h1;
		do @(posedge core_clk); while (pready !== 1'h1);
		rd = prdata;
		er = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask : apb

	// Hang guard, far beyond the expected run of about 1500 cycles.
	initial begin
		#2000000;
		mismatches++;
		final_report();
	end

	// Stage, write with random enables, read another entry, then look up.
	initial begin
		{arst_n, psel, penable, pwrite, paddr, pwdata} = '0;
		lookup_entry = '0;
		v = $urandom(58);
		repeat (16) @(posedge core_clk);
		arst_n <= 1'h1;
		repeat (12) begin
			p = 1 + $urandom % 3;
			e = $urandom % 16;
			f = $urandom % 16;
			for (int k = 0; k < 16; k++) begin
				v = $urandom % 256;
				apb(1'h1, k[7:0], v[7:0]);
				if (k != 12) dr[p][k] = v;
			end
			b = $urandom % 65536;
			apb(1'h1, 8'h10, b[15:8]);
			apb(1'h1, 8'h11, b[7:0]);
			apb(1'h0, 8'h10, 8'h00);
			chk(rd, b[15:8]);
			apb(1'h0, 8'h11, 8'h00);
			chk(rd, b[7:0]);
			apb(1'h1, 8'h12, 8'h10 + e[7:0]);
			for (int k = 0; k < 16; k++)
				if (b[15 - k] && k != 12) mem[p][e][k] = dr[p][k];
			apb(1'h0, 8'h12, 8'h00);
			chk(rd, 32'h50 + e);
			apb(1'h1, 8'h12, f[7:0]);
			apb(1'h0, 8'h12, 8'h00);
			chk(rd, 32'h20 + f);
			for (int k = 0; k < 16; k++) begin
				apb(1'h0, k[7:0], 8'h00);
				chk(rd, k == 12 ? 0 : mem[p][f][k]);
			end
			lookup_entry[p - 1] <= e[3:0];
			repeat (2) @(posedge core_clk);
			chk(process_rule_mask[p - 1],
				{mem[p][e][14][7:0], mem[p][e][15][7:0]});
			chk(map_mode[p - 1], mem[p][e][11][6:5]);
			chk({priority_mode[p - 1], priority_value[p - 1],
				remap_priority_enable[p - 1], remapped_priority[p - 1]},
				{mem[p][e][10][7:0], mem[p][e][11][7]});
			chk({match_mode[p - 1], match_enable_select[p - 1]},
				mem[p][e][1][5:2]);
		end
		p = 0;
		apb(1'h0, 8'h00, 8'h00);
		chk(er, 1'h1);
		p = 1;
		apb(1'h0, 8'h13, 8'h00);
		chk(er, 1'h1);
		chk(rd, 32'h0);
		final_report();
	end
endmodule : ati_table_access_bench
